// ### inc/ndm_pkg.sv
// Package for the network DMA pointer and address filter block.
// Assumes one 200 MHz clock and a classic Wishbone slave with 32-bit data.
package ndm_pkg;

  // ---------------------------------------------------------------
  // Register word indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [5:0] REG_TX_COUNT_LOW = 6'h00;
  localparam logic [5:0] REG_TX_COUNT_HIGH = 6'h01;
  localparam logic [5:0] REG_RX_RING_FIRST_PAGE = 6'h02;
  localparam logic [5:0] REG_RX_RING_LAST_PAGE = 6'h03;
  localparam logic [5:0] REG_RX_RING_GUARD_PAGE = 6'h04;
  localparam logic [5:0] REG_RX_WRITE_PAGE = 6'h05;
  localparam logic [5:0] REG_LOCAL_DMA_ADDR_LOW = 6'h06;
  localparam logic [5:0] REG_LOCAL_DMA_ADDR_HIGH = 6'h07;
  localparam logic [5:0] REG_HOST_XFER_START_LOW = 6'h08;
  localparam logic [5:0] REG_HOST_XFER_START_HIGH = 6'h09;
  localparam logic [5:0] REG_HOST_XFER_COUNT_LOW = 6'h0A;
  localparam logic [5:0] REG_HOST_XFER_COUNT_HIGH = 6'h0B;
  localparam logic [5:0] REG_HOST_XFER_ADDR_LOW = 6'h0C;
  localparam logic [5:0] REG_HOST_XFER_ADDR_HIGH = 6'h0D;
  localparam logic [5:0] REG_CONTROL = 6'h0E;
  localparam logic [5:0] REG_STATUS = 6'h0F;
  localparam logic [5:0] REG_STATION_ADDR_BASE = 6'h10;
  localparam logic [5:0] REG_HASH_FILTER_BASE = 6'h18;
  localparam logic [5:0] REG_ALIGN_ERROR_TALLY = 6'h20;
  localparam logic [5:0] REG_CRC_ERROR_TALLY = 6'h21;
  localparam logic [5:0] REG_LOST_FRAME_TALLY = 6'h22;

  // ---------------------------------------------------------------
  // Field positions and constants
  // ---------------------------------------------------------------
  localparam int CTL_START_BIT = 0;
  localparam int CTL_WORD_BIT = 1;
  localparam int CTL_MONITOR_BIT = 2;
  localparam int CTL_ACCEPT_MCAST_BIT = 3;
  localparam int CTL_PROMISC_BIT = 4;
  localparam int DA_BYTES = 6;
  localparam int HASH_BYTES = 8;
  localparam logic [7:0] TALLY_MAX = 8'hC0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [7:0] PAGE_LOW_BYTE = 8'h00;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [5:0] DA_BIT_LAST = 6'h2F;

  // ---------------------------------------------------------------
  // Bus and link carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } ndm_wb_req_t;

  // Receive link events from the serial front end
  typedef struct packed {
    logic frame_start;
    logic da_bit_valid;
    logic da_bit;
    logic frame_end;
    logic align_err;
    logic crc_err;
    logic rx_err;
  } ndm_rx_ev_t;

  // Local DMA events from the buffer engine
  typedef struct packed {
    logic tx_start;
    logic rx_start;
    logic byte_done;
    logic page_cross;
  } ndm_ldma_ev_t;

  typedef enum logic [1:0] {
    HX_IDLE = 2'b00,
    HX_RUN = 2'b01
  } ndm_hx_state_t;

endpackage

// ### hw/ndm_core.sv
// Network DMA pointers, station address filter, hash filter and tally counters.
// Assumes a Wishbone master, a serial receive front end and a buffer engine on clk_i.
//
// How it works
// - transmit length is 16 bits from low and high byte registers.
// - full 16-bit count is sent; nothing truncates long frames.
// - ring pages are 256 bytes; registers hold address bits 15-8 only.
// - next page equal to guard page aborts the local DMA.
// - write page marks reception start; receive error restores pointer from it.
// - current local DMA address readable as high and low bytes.
// - host transfer start address loads from low and high byte registers.
// - host transfer address steps two per word, one per byte.
// - host transfer count falls two per word, one per byte.
// - host transfer count is high byte register joined above low byte register.
// - current host transfer address readable as high and low bytes.
// - destination compared byte-wise with six station address registers.
// - first destination bit is the group indicator; bits arrive LSB first.
// - destination bits go through CRC; top six bits latched as hash.
// - hash decodes one of 64 filter bits; set bit accepts multicast.
// - filter bit k is bit k mod 8 of hash register k div 8.
// - three 8-bit tallies saturate at 192 and never wrap.
// - reading a tally clears it.
// - alignment tally counts recognised frames with alignment error.
// - CRC tally counts recognised frames with CRC error.
// - lost tally counts recognised frames lost for buffers or received in monitor.
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
module ndm_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ndm_pkg::ndm_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ndm_pkg::ndm_rx_ev_t rx_i,
  input wire ndm_pkg::ndm_ldma_ev_t ldma_i,
  input wire logic no_buffer_i,
  input wire logic hx_step_i,
  output logic [15:0] local_addr_o,
  output logic local_abort_o,
  output logic [15:0] tx_len_o,
  output logic [15:0] hx_addr_o,
  output logic hx_busy_o,
  output logic frame_accept_o
);
  import ndm_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdat;
    logic ack;
    logic [15:0] tx_count;
    logic [7:0] first_page;
    logic [7:0] last_page;
    logic [7:0] guard_page;
    logic [7:0] write_page;
    logic [15:0] local_addr;
    logic abort;
    logic [15:0] hx_start;
    logic [15:0] hx_count;
    logic [15:0] hx_addr;
    ndm_hx_state_t hx_state;
    logic busy;
    logic [7:0] control;
    logic [DA_BYTES*8-1:0] station;
    logic [HASH_BYTES*8-1:0] hash_bits;
    logic [7:0] align_tally;
    logic [7:0] crc_tally;
    logic [7:0] lost_tally;
    logic [47:0] da_shift;
    logic [5:0] da_cnt;
    logic da_done;
    logic [31:0] crc;
    logic [5:0] hash;
    logic group;
    logic recognised;
  } ndm_state_t;

  ndm_state_t s_r;
  ndm_state_t s_nxt;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Saturating increment used by all three tallies
  function automatic logic [7:0] tally_inc(input logic [7:0] v);
    tally_inc = (v >= TALLY_MAX) ? TALLY_MAX : v + 8'h01;
  endfunction

  // Byte lane 0 write strobe for one word index
  function automatic logic wr_hit(input ndm_wb_req_t r, input logic [5:0] idx);
    wr_hit = r.cyc && r.stb && r.we && r.sel[0] && (r.adr[7:2] == idx);
  endfunction

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
    crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? CRC_POLY : 32'h00000000);
  endfunction

  logic new_req;
  logic [5:0] ridx;
  logic [7:0] rbyte;
  logic [15:0] hx_step;
  logic [7:0] next_page;
  logic station_hit;
  logic hash_hit;
  logic [31:0] crc_last;

  assign new_req = wb_i.cyc && wb_i.stb && !s_r.ack;
  assign ridx = wb_i.adr[7:2];
  assign hx_step = s_r.control[CTL_WORD_BIT] ? STEP_WORD : STEP_BYTE;
  assign crc_last = crc_step(s_r.crc, rx_i.da_bit);

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    rbyte = ZERO_BYTE;
    if (ridx >= REG_STATION_ADDR_BASE && ridx < REG_STATION_ADDR_BASE + 6'(DA_BYTES)) begin
      rbyte = s_r.station[8*(ridx - REG_STATION_ADDR_BASE) +: 8];
    end else if (ridx >= REG_HASH_FILTER_BASE && ridx < REG_HASH_FILTER_BASE + 6'(HASH_BYTES)) begin
      rbyte = s_r.hash_bits[8*(ridx - REG_HASH_FILTER_BASE) +: 8];
    end else begin
      unique case (ridx)
        REG_TX_COUNT_LOW: rbyte = s_r.tx_count[7:0];
        REG_TX_COUNT_HIGH: rbyte = s_r.tx_count[15:8];
        REG_RX_RING_FIRST_PAGE: rbyte = s_r.first_page;
        REG_RX_RING_LAST_PAGE: rbyte = s_r.last_page;
        REG_RX_RING_GUARD_PAGE: rbyte = s_r.guard_page;
        REG_RX_WRITE_PAGE: rbyte = s_r.write_page;
        REG_LOCAL_DMA_ADDR_LOW: rbyte = s_r.local_addr[7:0];
        REG_LOCAL_DMA_ADDR_HIGH: rbyte = s_r.local_addr[15:8];
        REG_HOST_XFER_START_LOW: rbyte = s_r.hx_start[7:0];
        REG_HOST_XFER_START_HIGH: rbyte = s_r.hx_start[15:8];
        REG_HOST_XFER_COUNT_LOW: rbyte = s_r.hx_count[7:0];
        REG_HOST_XFER_COUNT_HIGH: rbyte = s_r.hx_count[15:8];
        REG_HOST_XFER_ADDR_LOW: rbyte = s_r.hx_addr[7:0];
        REG_HOST_XFER_ADDR_HIGH: rbyte = s_r.hx_addr[15:8];
        REG_CONTROL: rbyte = s_r.control;
        REG_STATUS: rbyte = {5'h00, s_r.group, s_r.abort, s_r.hx_state == HX_RUN};
        REG_ALIGN_ERROR_TALLY: rbyte = s_r.align_tally;
        REG_CRC_ERROR_TALLY: rbyte = s_r.crc_tally;
        REG_LOST_FRAME_TALLY: rbyte = s_r.lost_tally;
        default: rbyte = ZERO_BYTE;
      endcase
    end
  end

  // Next page with wrap back to first when the page after the current one is the last page
  assign next_page = (s_r.local_addr[15:8] + 8'h01 == s_r.last_page) ? s_r.first_page
                     : s_r.local_addr[15:8] + 8'h01;
  assign station_hit = (s_r.da_shift == s_r.station);
  assign hash_hit = s_r.hash_bits[s_r.hash];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic rd_tally;
    logic recog;
    rd_tally = 1'b0;
    recog = 1'b0;
    s_nxt = s_r;
    s_nxt.ack = new_req;
    if (new_req && !wb_i.we) begin
      s_nxt.rdat = {24'h000000, rbyte};
    end
    // Start clears first, so a written one stands for exactly one cycle
    s_nxt.control[CTL_START_BIT] = 1'b0;
    // Register writes
    if (new_req) begin
      if (wr_hit(wb_i, REG_TX_COUNT_LOW)) s_nxt.tx_count[7:0] = wb_i.dat[7:0];
      if (wr_hit(wb_i, REG_TX_COUNT_HIGH)) s_nxt.tx_count[15:8] = wb_i.dat[7:0];
      if (wr_hit(wb_i, REG_RX_RING_FIRST_PAGE)) s_nxt.first_page = wb_i.dat[7:0];
      if (wr_hit(wb_i, REG_RX_RING_LAST_PAGE)) s_nxt.last_page = wb_i.dat[7:0];
      if (wr_hit(wb_i, REG_RX_RING_GUARD_PAGE)) s_nxt.guard_page = wb_i.dat[7:0];
      if (wr_hit(wb_i, REG_RX_WRITE_PAGE)) s_nxt.write_page = wb_i.dat[7:0];
      if (wr_hit(wb_i, REG_HOST_XFER_START_LOW)) s_nxt.hx_start[7:0] = wb_i.dat[7:0];
      if (wr_hit(wb_i, REG_HOST_XFER_START_HIGH)) s_nxt.hx_start[15:8] = wb_i.dat[7:0];
      if (wr_hit(wb_i, REG_HOST_XFER_COUNT_LOW)) s_nxt.hx_count[7:0] = wb_i.dat[7:0];
      if (wr_hit(wb_i, REG_HOST_XFER_COUNT_HIGH)) s_nxt.hx_count[15:8] = wb_i.dat[7:0];
      if (wr_hit(wb_i, REG_CONTROL)) s_nxt.control = wb_i.dat[7:0];
      for (int i = 0; i < DA_BYTES; i++) begin
        if (wr_hit(wb_i, REG_STATION_ADDR_BASE + 6'(i))) s_nxt.station[8*i +: 8] = wb_i.dat[7:0];
      end
      for (int i = 0; i < HASH_BYTES; i++) begin
        if (wr_hit(wb_i, REG_HASH_FILTER_BASE + 6'(i))) s_nxt.hash_bits[8*i +: 8] = wb_i.dat[7:0];
      end
    end
    // Host transfer engine
    unique case (s_r.hx_state)
      HX_IDLE: begin
        if (s_r.control[CTL_START_BIT]) begin
          s_nxt.hx_addr = s_r.hx_start;
          s_nxt.hx_state = (s_r.hx_count == 16'h0000) ? HX_IDLE : HX_RUN;
        end
      end
      HX_RUN: begin
        if (hx_step_i) begin
          s_nxt.hx_addr = s_r.hx_addr + hx_step;
          // Odd count in word mode ends without wrapping below zero
          s_nxt.hx_count = (s_r.hx_count <= hx_step) ? 16'h0000 : s_r.hx_count - hx_step;
          if (s_r.hx_count <= hx_step) s_nxt.hx_state = HX_IDLE;
        end
      end
    endcase
    s_nxt.busy = (s_nxt.hx_state == HX_RUN);
    // Local DMA pointer
    if (ldma_i.tx_start) begin
      s_nxt.local_addr = {s_r.local_addr[15:8], PAGE_LOW_BYTE};
      s_nxt.abort = 1'b0;
    end
    if (ldma_i.rx_start) begin
      s_nxt.local_addr = {s_r.write_page, PAGE_LOW_BYTE};
      s_nxt.abort = 1'b0;
    end else if (ldma_i.page_cross && !s_r.abort) begin
      if (next_page == s_r.guard_page) begin
        s_nxt.abort = 1'b1;
      end else begin
        s_nxt.local_addr = {next_page, PAGE_LOW_BYTE};
      end
    end else if (ldma_i.byte_done && !s_r.abort) begin
      s_nxt.local_addr = s_r.local_addr + 16'h0001;
    end
    // Receive error rewinds to the first page of the frame
    if (rx_i.rx_err) begin
      s_nxt.local_addr = {s_r.write_page, PAGE_LOW_BYTE};
    end else if (rx_i.frame_end && !rx_i.crc_err && !s_r.abort && !s_r.control[CTL_MONITOR_BIT]) begin
      // Good frame: commit the page after the one in use
      s_nxt.write_page = next_page;
    end
    // Destination address capture and hash
    if (rx_i.frame_start) begin
      s_nxt.da_cnt = 6'h00;
      s_nxt.da_done = 1'b0;
      s_nxt.crc = CRC_INIT;
      s_nxt.recognised = 1'b0;
    end else if (rx_i.da_bit_valid && !s_r.da_done) begin
      s_nxt.da_shift = {rx_i.da_bit, s_r.da_shift[47:1]};
      if (s_r.da_cnt == 6'h00) s_nxt.group = rx_i.da_bit;
      s_nxt.crc = crc_last;
      s_nxt.da_cnt = s_r.da_cnt + 6'h01;
      if (s_r.da_cnt == DA_BIT_LAST) begin
        s_nxt.hash = crc_last[31:26];
        s_nxt.da_done = 1'b1;
      end
    end
    recog = s_r.da_done && (s_r.group ? (s_r.control[CTL_ACCEPT_MCAST_BIT] && hash_hit)
                                       : (station_hit || s_r.control[CTL_PROMISC_BIT]));
    s_nxt.recognised = rx_i.frame_start ? 1'b0 : recog;
    // Tallies: event beats clear in the same cycle
    if (new_req && !wb_i.we) begin
      if (ridx == REG_ALIGN_ERROR_TALLY) s_nxt.align_tally = ZERO_BYTE;
      if (ridx == REG_CRC_ERROR_TALLY) s_nxt.crc_tally = ZERO_BYTE;
      if (ridx == REG_LOST_FRAME_TALLY) s_nxt.lost_tally = ZERO_BYTE;
    end
    rd_tally = new_req && !wb_i.we;
    if (rx_i.frame_end && recog) begin
      if (rx_i.align_err) begin
        s_nxt.align_tally = tally_inc((rd_tally && ridx == REG_ALIGN_ERROR_TALLY) ? ZERO_BYTE
                                      : s_r.align_tally);
      end
      if (rx_i.crc_err) begin
        s_nxt.crc_tally = tally_inc((rd_tally && ridx == REG_CRC_ERROR_TALLY) ? ZERO_BYTE
                                    : s_r.crc_tally);
      end
      if (s_r.control[CTL_MONITOR_BIT] || no_buffer_i) begin
        s_nxt.lost_tally = tally_inc((rd_tally && ridx == REG_LOST_FRAME_TALLY) ? ZERO_BYTE
                                     : s_r.lost_tally);
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign local_addr_o = s_r.local_addr;
  assign local_abort_o = s_r.abort;
  assign tx_len_o = s_r.tx_count;
  assign hx_addr_o = s_r.hx_addr;
  assign hx_busy_o = s_r.busy;
  assign frame_accept_o = s_r.recognised;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking chk_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  tally_saturate_a: assert property (
    s_r.crc_tally <= TALLY_MAX && s_r.align_tally <= TALLY_MAX && s_r.lost_tally <= TALLY_MAX)
    else $error("tally above limit");
  sat_hold_a: assert property (
    (s_r.crc_tally == TALLY_MAX && !(new_req && !wb_i.we && ridx == REG_CRC_ERROR_TALLY))
    |=> s_r.crc_tally == TALLY_MAX)
    else $error("saturated tally moved");
  tally_read_clear_a: assert property (
    (new_req && !wb_i.we && ridx == REG_CRC_ERROR_TALLY && !rx_i.frame_end) |=> s_r.crc_tally == ZERO_BYTE)
    else $error("tally not cleared by read");
  align_clear_a: assert property (
    (new_req && !wb_i.we && ridx == REG_ALIGN_ERROR_TALLY && !rx_i.frame_end)
    |=> s_r.align_tally == ZERO_BYTE)
    else $error("alignment tally not cleared");
  lost_clear_a: assert property (
    (new_req && !wb_i.we && ridx == REG_LOST_FRAME_TALLY && !rx_i.frame_end)
    |=> s_r.lost_tally == ZERO_BYTE)
    else $error("lost tally not cleared");

  ack_answer_a: assert property (
    new_req |=> wb_ack_o)
    else $error("request not answered");
  ack_one_cycle_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  start_clear_a: assert property (
    s_r.control[CTL_START_BIT] |=> !s_r.control[CTL_START_BIT])
    else $error("start bit stuck");
  hx_load_a: assert property (
    (s_r.hx_state == HX_IDLE && s_r.control[CTL_START_BIT]) |=> s_r.hx_addr == $past(s_r.hx_start))
    else $error("host start address not loaded");
  hx_addr_step_a: assert property (
    (s_r.hx_state == HX_RUN && hx_step_i && !s_r.control[CTL_START_BIT]) |=>
    s_r.hx_addr == $past(s_r.hx_addr) + $past(hx_step))
    else $error("host address step wrong");
  hx_count_step_a: assert property (
    (s_r.hx_state == HX_RUN && hx_step_i && s_r.hx_count > hx_step)
    |=> s_r.hx_count == $past(s_r.hx_count) - $past(hx_step))
    else $error("host count step wrong");
  hx_count_end_a: assert property (
    (s_r.hx_state == HX_RUN && hx_step_i && s_r.hx_count <= hx_step) |=>
    s_r.hx_state == HX_IDLE && s_r.hx_count == 16'h0000)
    else $error("host transfer did not end");
  hx_idle_hold_a: assert property (
    (s_r.hx_state == HX_IDLE && !s_r.control[CTL_START_BIT]) |=> $stable(s_r.hx_addr))
    else $error("host address moved while idle");

  ring_guard_a: assert property (
    (ldma_i.page_cross && !ldma_i.rx_start && !rx_i.rx_err && !s_r.abort && next_page == s_r.guard_page)
    |=> s_r.abort)
    else $error("guard page not honoured");
  ring_next_a: assert property (
    (ldma_i.page_cross && !ldma_i.rx_start && !rx_i.rx_err && !s_r.abort && next_page != s_r.guard_page)
    |=> s_r.local_addr == {$past(next_page), PAGE_LOW_BYTE})
    else $error("next ring page wrong");
  abort_clear_a: assert property (
    ldma_i.rx_start |=> !s_r.abort)
    else $error("abort not cleared");
  rx_rewind_a: assert property (
    rx_i.rx_err |=> s_r.local_addr == {$past(s_r.write_page), PAGE_LOW_BYTE})
    else $error("pointer not restored");
  page_align_a: assert property (
    (ldma_i.rx_start && !rx_i.rx_err) |=> s_r.local_addr[7:0] == PAGE_LOW_BYTE)
    else $error("page not aligned");
  group_bit_a: assert property (
    (rx_i.da_bit_valid && !rx_i.frame_start && !s_r.da_done && s_r.da_cnt == 6'h00)
    |=> s_r.group == $past(rx_i.da_bit))
    else $error("group bit not taken");
  hash_latch_a: assert property (
    (rx_i.da_bit_valid && !rx_i.frame_start && !s_r.da_done && s_r.da_cnt == DA_BIT_LAST)
    |=> s_r.da_done && s_r.hash == $past(crc_last[31:26]))
    else $error("hash not latched");

endmodule // ndm_core

// ### dv/ndm_rx_model.sv
// Serial receive front end model: frame start, destination bits, frame end.
// Assumes the core samples every event on the rising edge of clk_i.
`timescale 1ns/100ps
module ndm_rx_model (
  input wire logic clk_i,
  output ndm_pkg::ndm_rx_ev_t rx_o,
  output logic no_buffer_o
);
  import ndm_pkg::*;

  initial begin
    rx_o = '0;
    no_buffer_o = 1'b0;
  end

  // Levels outside frame end show the inverse, so a late sample is caught
  task automatic send(input logic [47:0] da, input logic ae, input logic ce, input logic nb);
    @(posedge clk_i);
    rx_o.frame_start <= 1'b1;
    @(posedge clk_i);
    rx_o.frame_start <= 1'b0;
    for (int i = 0; i < 48; i++) begin
      @(posedge clk_i);
      rx_o.da_bit_valid <= 1'b1;
      rx_o.da_bit <= da[i];
      @(posedge clk_i);
      rx_o.da_bit_valid <= 1'b0;
      rx_o.da_bit <= ~da[i];
    end
    @(posedge clk_i);
    rx_o.frame_end <= 1'b1;
    rx_o.align_err <= ae;
    rx_o.crc_err <= ce;
    no_buffer_o <= nb;
    @(posedge clk_i);
    rx_o.frame_end <= 1'b0;
    rx_o.align_err <= ~ae;
    rx_o.crc_err <= ~ce;
    no_buffer_o <= ~nb;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic err_pulse;
    @(posedge clk_i);
    rx_o.rx_err <= 1'b1;
    @(posedge clk_i);
    rx_o.rx_err <= 1'b0;
  endtask
endmodule // ndm_rx_model

// ### dv/ndm_core_tb.sv
// Testbench for ndm_core: registers, receive ring, host transfer, filters, tallies.
// Assumes the receive model beside it; bus tasks wait for ack however late it comes.
`timescale 1ns/100ps
module ndm_core_tb;
  import ndm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  ndm_wb_req_t wb = '0;
  ndm_ldma_ev_t ldma = '0;
  ndm_rx_ev_t rx;
  logic no_buf;
  logic hx_step = 1'b0;
  logic [31:0] wb_dat;
  logic wb_ack, abort, busy, accept;
  logic [15:0] laddr, tx_len, hx_addr;
  logic [31:0] rd_v;
  logic [15:0] tl [2] = '{16'h05DD, 16'hFFFF};
  logic [47:0] sta = 48'h665544332210;
  logic [47:0] mc = 48'h0000005E0001;
  logic [5:0] h;
  int n_fail = 0;
  int samples_checked = 0;

  ndm_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .rx_i(rx), .ldma_i(ldma), .no_buffer_i(no_buf), .hx_step_i(hx_step), .local_addr_o(laddr),
    .local_abort_o(abort), .tx_len_o(tx_len), .hx_addr_o(hx_addr), .hx_busy_o(busy),
    .frame_accept_o(accept));
  ndm_rx_model i_rx (.clk_i(clk_i), .rx_o(rx), .no_buffer_o(no_buf));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // Access and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request stands until ack is seen high at a rising edge; data is taken and the request dropped there
  task automatic wbx(input logic [5:0] idx, input logic we, input logic [7:0] d);
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: {idx, 2'b00}, dat: {24'h000000, d}};
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd_v = wb_dat;
    wb <= '0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wbx(idx, 1'b1, d);
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] idx, input logic [7:0] exp);
    wbx(idx, 1'b0, 8'h00);
    chk(nm, rd_v, {24'h000000, exp});
  endtask

  task automatic ev(input logic [3:0] e);
    @(posedge clk_i);
    ldma <= ndm_ldma_ev_t'(e);
    @(posedge clk_i);
    ldma <= '0;
    repeat (2) @(negedge clk_i);
  endtask

  task automatic step;
    @(posedge clk_i);
    hx_step <= 1'b1;
    @(posedge clk_i);
    hx_step <= 1'b0;
  endtask

  task automatic hx_run(input logic [15:0] sa, input logic [15:0] cnt, input logic [7:0] ctl,
                        input int n, input logic [15:0] st);
    wr(REG_HOST_XFER_COUNT_LOW, cnt[7:0]);
    wr(REG_HOST_XFER_COUNT_HIGH, cnt[15:8]);
    wr(REG_HOST_XFER_START_LOW, sa[7:0]);
    wr(REG_HOST_XFER_START_HIGH, sa[15:8]);
    wr(REG_CONTROL, ctl);
    repeat (2) @(negedge clk_i);
    chk("hx_addr start", {16'h0000, hx_addr}, {16'h0000, sa});
    repeat (n - 1) step;
    repeat (2) @(negedge clk_i);
    chk("hx_busy mid", {31'h00000000, busy}, 32'h00000001);
    step;
    repeat (2) @(negedge clk_i);
    chk("hx_addr end", {16'h0000, hx_addr}, {16'h0000, 16'(sa + n * st)});
    chk("hx_busy end", {31'h00000000, busy}, 32'h00000000);
  endtask

  function automatic logic [5:0] hash_of(input logic [47:0] da);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 48; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? CRC_POLY : 32'h00000000);
    return c[31:26];
  endfunction

  task automatic test_done;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #250000;
    n_fail++;
    test_done;
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("tx_count_low", REG_TX_COUNT_LOW, 8'h00);
    wr(6'h3F, 8'hA5);
    rd_chk("unmapped", 6'h3F, 8'h00);
    wr(REG_LOCAL_DMA_ADDR_LOW, 8'h5A);
    rd_chk("local_low ro", REG_LOCAL_DMA_ADDR_LOW, 8'h00);
    foreach (tl[i]) begin
      wr(REG_TX_COUNT_LOW, tl[i][7:0]);
      wr(REG_TX_COUNT_HIGH, tl[i][15:8]);
      rd_chk("tx_count_high", REG_TX_COUNT_HIGH, tl[i][15:8]);
      chk("tx_len", {16'h0000, tx_len}, {16'h0000, tl[i]});
    end
    wr(REG_RX_RING_FIRST_PAGE, 8'h40);
    wr(REG_RX_RING_LAST_PAGE, 8'h43);
    wr(REG_RX_RING_GUARD_PAGE, 8'h42);
    wr(REG_RX_WRITE_PAGE, 8'h40);
    ev(4'b0100);
    chk("local rx_start", {16'h0000, laddr}, 32'h00004000);
    ev(4'b0010);
    rd_chk("local_low", REG_LOCAL_DMA_ADDR_LOW, 8'h01);
    rd_chk("local_high", REG_LOCAL_DMA_ADDR_HIGH, 8'h40);
    ev(4'b0001);
    chk("local page", {16'h0000, laddr}, 32'h00004100);
    chk("abort clear", {31'h00000000, abort}, 32'h00000000);
    ev(4'b0001);
    chk("abort guard", {31'h00000000, abort}, 32'h00000001);
    i_rx.err_pulse;
    repeat (2) @(negedge clk_i);
    chk("local restore", {16'h0000, laddr}, 32'h00004000);
    ev(4'b1000);
    chk("abort tx_start", {31'h00000000, abort}, 32'h00000000);
    hx_run(16'h12FE, 16'h0102, 8'h01, 258, STEP_BYTE);
    hx_run(16'h0100, 16'h0004, 8'h03, 2, STEP_WORD);
    rd_chk("hx_low", REG_HOST_XFER_ADDR_LOW, 8'h04);
    rd_chk("hx_high", REG_HOST_XFER_ADDR_HIGH, 8'h01);
    for (int i = 0; i < DA_BYTES; i++) wr(REG_STATION_ADDR_BASE + 6'(i), sta[8 * i +: 8]);
    wr(REG_CONTROL, 8'h00);
    i_rx.send(sta, 1'b0, 1'b1, 1'b0);
    chk("accept", {31'h00000000, accept}, 32'h00000001);
    i_rx.send(sta, 1'b1, 1'b1, 1'b0);
    i_rx.send(sta ^ 48'h010000000000, 1'b1, 1'b1, 1'b0);
    chk("reject", {31'h00000000, accept}, 32'h00000000);
    i_rx.send(sta ^ 48'h000000000100, 1'b1, 1'b1, 1'b0);
    rd_chk("crc tally", REG_CRC_ERROR_TALLY, 8'h02);
    rd_chk("align tally", REG_ALIGN_ERROR_TALLY, 8'h01);
    rd_chk("crc cleared", REG_CRC_ERROR_TALLY, 8'h00);
    h = hash_of(mc);
    wr(REG_HASH_FILTER_BASE + {3'b000, h[5:3]}, 8'h01 << h[2:0]);
    wr(REG_CONTROL, 8'h08);
    i_rx.send(mc, 1'b0, 1'b1, 1'b0);
    rd_chk("status", REG_STATUS, 8'h04);
    wr(REG_HASH_FILTER_BASE + {3'b000, h[5:3]}, ~(8'h01 << h[2:0]));
    i_rx.send(mc, 1'b0, 1'b1, 1'b0);
    chk("mcast reject", {31'h00000000, accept}, 32'h00000000);
    for (int i = 0; i < HASH_BYTES; i++) wr(REG_HASH_FILTER_BASE + 6'(i), 8'hFF);
    i_rx.send(mc ^ 48'h123456789A00, 1'b0, 1'b1, 1'b0);
    rd_chk("crc mcast", REG_CRC_ERROR_TALLY, 8'h02);
    wr(REG_CONTROL, 8'h00);
    repeat (200) i_rx.send(sta, 1'b1, 1'b1, 1'b0);
    rd_chk("align sat", REG_ALIGN_ERROR_TALLY, TALLY_MAX);
    rd_chk("crc sat", REG_CRC_ERROR_TALLY, TALLY_MAX);
    i_rx.send(sta, 1'b0, 1'b0, 1'b1);
    wr(REG_CONTROL, 8'h04);
    i_rx.send(sta, 1'b0, 1'b0, 1'b0);
    i_rx.send(sta ^ 48'h000000000100, 1'b0, 1'b0, 1'b0);
    rd_chk("lost tally", REG_LOST_FRAME_TALLY, 8'h02);
    test_done;
  end
endmodule // ndm_core_tb
